// [design/gst_pkg.sv]
// Purpose: Shared constants and types of the gated sixteen-bit timer core
// Assumes: One 125 MHz clock; every slower rate is an enable pulse
// Notes: Contract list below, one line per item
//
// Contract
// - Sixteen-bit up counter seen as two bytes; a byte write replaces that byte.
// - Off when on bit is 0; counts freely or, gated, only when gate permits.
// - Clock select 11 slow oscillator, 10 external pin, 01 system, 00 system/4.
// - System clock selection at prescale 1 advances the counter once every system clock.
// - External selection counts rising edges, synchronised or asynchronous.
// - External counting needs a falling edge after reset, write, disable, low re-enable.
// - Two-bit prescale field divides the selected clock by 1, 2, 4 or 8.
// - Prescale counter is hidden from software and cleared by any byte write.
// - Sync-disable bit set lets the external input skip the phase-alignment stage.
// - Asynchronous external counting runs in sleep and its overflow wakes the core.
// - Switching sync mode may lose or add one increment; tolerated.
// - Byte reads while counting asynchronously return a stable registered value.
// - Counter wraps from all ones to zero and sets a sticky overflow flag.
// - Gate polarity 0 counts while gate source low, 1 while high.
// - Gate source 00 pin, 01 companion wrap pulse, 10 comparator one, 11 comparator two.
package gst_pkg;
  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int COUNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int PRE_W = 3;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [1:0] SYSDIV_LAST = 2'h3;
  localparam logic [1:0] SYSDIV_RST = 2'h0;
  localparam logic [2:0] PRE_RST = 3'h0;
  localparam logic [2:0] PRE_ONE = 3'h1;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    GST_CS_SYS_DIV4 = 2'b00,
    GST_CS_SYS = 2'b01,
    GST_CS_EXT = 2'b10,
    GST_CS_LFOSC = 2'b11
  } gst_clk_sel_t;

  typedef enum logic [1:0] {
    GST_GS_PIN = 2'b00,
    GST_GS_WRAP = 2'b01,
    GST_GS_CMP1 = 2'b10,
    GST_GS_CMP2 = 2'b11
  } gst_gate_sel_t;
endpackage

// [design/gst_prescaler.sv]
// Purpose: Divide a tick enable by 1, 2, 4 or 8
// Assumes: tick_i is a one-cycle enable on clk_i
// Notes: Count is hidden from software; clr_i restarts it
`timescale 1ns/100ps
module gst_prescaler #(
  parameter int PRE_W = gst_pkg::PRE_W
) (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic tick_i, // Selected clock tick
  input wire logic clr_i, // Clear the count
  input wire logic [1:0] ratio_i, // Log2 of the division
  output logic pulse_o, // Divided tick, combinational
  output logic [PRE_W-1:0] count_o // Internal count, for checks only
);
  logic [PRE_W-1:0] cnt_r;
  logic [PRE_W-1:0] last;
  logic [PRE_W:0] span;

  // Terminal count is 2^ratio - 1; a count left above it by a ratio change ends at once
  always_comb begin
    span = (PRE_W+1)'(1) << ratio_i;
    last = PRE_W'(span - (PRE_W+1)'(1));
    pulse_o = tick_i && !clr_i && (cnt_r >= last);
  end

  // Prescale count, cleared by a byte write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= gst_pkg::PRE_RST;
    end else if (clr_i) begin
      cnt_r <= gst_pkg::PRE_RST;
    end else if (tick_i) begin
      cnt_r <= pulse_o ? gst_pkg::PRE_RST : cnt_r + gst_pkg::PRE_ONE;
    end
  end

  assign count_o = cnt_r;
endmodule

// [design/gst_timer_core.sv]
// Purpose: Sixteen-bit gated timer/counter core with prescaler and overflow flag
// Assumes: Pin-level inputs are asynchronous; companion pulse and comparators are on clk_i
// Notes: Asynchronous external mode still samples through two flops, minus the phase stage
`timescale 1ns/100ps
module gst_timer_core (
  input wire logic clk_i, // System clock, 125 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic counter_on_bit_i, // Counter on
  input wire logic gate_enable_bit_i, // Gated counting
  input wire logic gate_polarity_bit_i, // Gate active level
  input wire logic [1:0] gate_source_field_i, // Gate source select
  input wire logic [1:0] clock_select_field_i, // Count clock select
  input wire logic [1:0] prescale_field_i, // Prescale select
  input wire logic sync_disable_bit_i, // 1 = asynchronous external
  input wire logic sleep_i, // Core is asleep
  input wire logic external_count_input_i, // External clock pin
  input wire logic low_freq_internal_osc_i, // Slow oscillator
  input wire logic gate_input_pin_i, // Gate pin
  input wire logic companion_timer_wrap_pulse_i, // Companion timer wrap
  input wire logic comparator_one_output_i, // Comparator one
  input wire logic comparator_two_output_i, // Comparator two
  input wire logic wr_low_i, // Write low byte strobe
  input wire logic wr_high_i, // Write high byte strobe
  input wire logic [7:0] wr_data_i, // Write data
  input wire logic flag_clr_i, // Clear overflow flag
  output logic [7:0] count_low_byte_o, // Counter low byte
  output logic [7:0] count_high_byte_o, // Counter high byte
  output logic overflow_flag_o, // Sticky overflow flag
  output logic wake_o // Wake pulse on overflow in sleep
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] ext_s_r, osc_s_r, gpin_s_r;
  logic ext_ph_r, ext_prev_r, osc_prev_r;

  // Two flops for every pin-level input
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_s_r <= 2'h0;
      osc_s_r <= 2'h0;
      gpin_s_r <= 2'h0;
    end else begin
      ext_s_r <= {ext_s_r[0], external_count_input_i};
      osc_s_r <= {osc_s_r[0], low_freq_internal_osc_i};
      gpin_s_r <= {gpin_s_r[0], gate_input_pin_i};
    end
  end

  // ****************************************************************
  // External edge path
  // ****************************************************************
  logic async_mode, ext_lvl, ext_rise, ext_fall, osc_rise, armed_r, wr_any;
  assign async_mode = sync_disable_bit_i;
  assign ext_lvl = async_mode ? ext_s_r[1] : ext_ph_r;
  assign ext_rise = ext_lvl && !ext_prev_r;
  assign ext_fall = !ext_lvl && ext_prev_r;
  assign osc_rise = osc_s_r[1] && !osc_prev_r;
  assign wr_any = wr_low_i || wr_high_i;

  // Phase-alignment stage used only in synchronous mode; it stops in sleep
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_ph_r <= 1'b0;
      ext_prev_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      if (!sleep_i) begin
        ext_ph_r <= ext_s_r[1];
      end
      ext_prev_r <= ext_lvl;
      osc_prev_r <= osc_s_r[1];
    end
  end

  // Falling edge arms counting; reset, write or disable disarm it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_r <= 1'b0;
    end else if (wr_any || !counter_on_bit_i) begin
      armed_r <= 1'b0;
    end else if (ext_fall) begin
      armed_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Gate and tick selection
  // ****************************************************************
  logic gate_src, gate_ok, run, tick, pre_pulse, inc;
  logic [1:0] sysdiv_r;
  logic [gst_pkg::PRE_W-1:0] pre_cnt;

  // Gate source mux and polarity
  always_comb begin
    unique case (gst_pkg::gst_gate_sel_t'(gate_source_field_i))
      gst_pkg::GST_GS_PIN: gate_src = gpin_s_r[1];
      gst_pkg::GST_GS_WRAP: gate_src = companion_timer_wrap_pulse_i;
      gst_pkg::GST_GS_CMP1: gate_src = comparator_one_output_i;
      gst_pkg::GST_GS_CMP2: gate_src = comparator_two_output_i;
    endcase
  end
  assign gate_ok = gate_polarity_bit_i ? gate_src : !gate_src;
  assign run = counter_on_bit_i && (!gate_enable_bit_i || gate_ok);

  // System clock divide-by-four enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sysdiv_r <= gst_pkg::SYSDIV_RST;
    end else begin
      sysdiv_r <= sysdiv_r + 2'h1;
    end
  end

  // Count clock select; only asynchronous external ticks survive sleep
  always_comb begin
    unique case (gst_pkg::gst_clk_sel_t'(clock_select_field_i))
      gst_pkg::GST_CS_SYS_DIV4: tick = !sleep_i && (sysdiv_r == gst_pkg::SYSDIV_LAST);
      gst_pkg::GST_CS_SYS: tick = !sleep_i;
      gst_pkg::GST_CS_EXT: tick = ext_rise && armed_r && (async_mode || !sleep_i);
      gst_pkg::GST_CS_LFOSC: tick = !sleep_i && osc_rise;
    endcase
  end

  gst_prescaler #(
    .PRE_W(gst_pkg::PRE_W)
  ) u_pre (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick && run),
    .clr_i(wr_any),
    .ratio_i(prescale_field_i),
    .pulse_o(pre_pulse),
    .count_o(pre_cnt)
  );

  assign inc = pre_pulse && !wr_any;

  // ****************************************************************
  // Counter, flag and wake
  // ****************************************************************
  logic [15:0] count_r;
  logic ovf_evt, flag_r, wake_r;
  assign ovf_evt = inc && (count_r == gst_pkg::COUNT_MAX);

  // Counter: writes win over increments
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= gst_pkg::COUNT_RST;
    end else if (wr_any) begin
      if (wr_low_i) begin
        count_r[7:0] <= wr_data_i;
      end
      if (wr_high_i) begin
        count_r[15:8] <= wr_data_i;
      end
    end else if (inc) begin
      count_r <= count_r + gst_pkg::COUNT_ONE;
    end
  end

  // Sticky overflow flag; a set beats a clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= 1'b0;
    end else if (ovf_evt) begin
      flag_r <= 1'b1;
    end else if (flag_clr_i) begin
      flag_r <= 1'b0;
    end
  end

  // Wake pulse for an overflow while asleep
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= ovf_evt && sleep_i;
    end
  end

  assign count_low_byte_o = count_r[7:0];
  assign count_high_byte_o = count_r[15:8];
  assign overflow_flag_o = flag_r;
  assign wake_o = wake_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_quiet;
    !wr_any && !inc;
  endsequence
  sequence s_disarm;
    wr_any || !counter_on_bit_i;
  endsequence

  property p_off_hold;
    @(posedge clk_i) disable iff (!rst_n_i) !counter_on_bit_i && !wr_any |=> $stable(count_r);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("count moved while off");

  property p_wr_low;
    @(posedge clk_i) disable iff (!rst_n_i) wr_low_i |=> count_low_byte_o == $past(wr_data_i);
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low byte write lost");

  property p_wr_high;
    @(posedge clk_i) disable iff (!rst_n_i)
      wr_high_i && !wr_low_i |=> count_high_byte_o == $past(wr_data_i) && $stable(count_low_byte_o);
  endproperty
  a_wr_high: assert property (p_wr_high) else $error("high byte write wrong");

  property p_wrap;
    @(posedge clk_i) disable iff (!rst_n_i) ovf_evt |=> count_r == gst_pkg::COUNT_RST && overflow_flag_o;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap or flag missing");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (!rst_n_i) overflow_flag_o && !flag_clr_i |=> overflow_flag_o;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_sys_rate;
    @(posedge clk_i) disable iff (!rst_n_i)
      (counter_on_bit_i && !gate_enable_bit_i && clock_select_field_i == gst_pkg::GST_CS_SYS
       && prescale_field_i == 2'b00 && !sleep_i && !wr_any)
      |=> count_r == $past(count_r) + gst_pkg::COUNT_ONE;
  endproperty
  a_sys_rate: assert property (p_sys_rate) else $error("system clock rate wrong");

  property p_gate_hold;
    @(posedge clk_i) disable iff (!rst_n_i) gate_enable_bit_i && !gate_ok ##0 s_quiet |=> $stable(count_r);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("counted with gate closed");

  property p_need_fall;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_disarm ##1 (!ext_fall && clock_select_field_i == gst_pkg::GST_CS_EXT) |-> !inc;
  endproperty
  a_need_fall: assert property (p_need_fall) else $error("counted without falling edge");

  property p_pre_clear;
    @(posedge clk_i) disable iff (!rst_n_i) wr_any |=> pre_cnt == gst_pkg::PRE_RST;
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");

  property p_sleep_stop;
    @(posedge clk_i) disable iff (!rst_n_i)
      sleep_i && !(async_mode && clock_select_field_i == gst_pkg::GST_CS_EXT) |-> !inc;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("counted in sleep");

  property p_wake;
    @(posedge clk_i) disable iff (!rst_n_i) ovf_evt && sleep_i |=> wake_o ##1 !wake_o || ovf_evt;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse wrong");
endmodule

// [sim/gst_ext_src.sv]
// Purpose: External count source model driving the timer core count pin
// Assumes: A burst is started by a one-cycle go pulse on clk_i
// Notes: Pin rests low between bursts; each burst opens with one priming pulse
`timescale 1ns/100ps
module gst_ext_src (
  input wire logic clk_i, // System clock
  input wire logic go_i, // Start a burst
  input wire logic [7:0] n_i, // Rising edges that should count
  input wire logic [7:0] half_i, // Half period in clocks
  output logic pin_o, // External count pin
  output logic busy_o // Burst running
);
  // ****************************************************************
  // Burst generator
  // ****************************************************************
  // Priming pulse first: its rise must not count, its fall arms the counter
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        busy_o = 1'b1;
        for (int i = 0; i <= int'(n_i); i++) begin
          #3 pin_o = 1'b1;
          repeat (half_i) @(posedge clk_i);
          #3 pin_o = 1'b0;
          repeat (half_i) @(posedge clk_i);
        end
        busy_o = 1'b0;
      end
    end
  end
endmodule

// [sim/tb.sv]
// Purpose: Self-checking bench of the gated sixteen-bit timer core
// Assumes: Inputs change 1 ns after each rising clock edge; the external count pin 3 ns after
// Notes: Table rows cover internal clocks and gating; hand tests cover the rest
`timescale 1ns/100ps
module tb;
  typedef struct {int on; int ge; int pol; int gl; int gs; int cs; int pre; int n; int exp; int tol;} gst_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic on = 1'b0, ge = 1'b0, pol = 1'b0, sdis = 1'b0, sleep = 1'b0, lfo = 1'b0;
  logic gpin = 1'b0, wrap = 1'b0, c1 = 1'b0, c2 = 1'b0, wr_lo = 1'b0, wr_hi = 1'b0, fclr = 1'b0;
  logic [1:0] gs = 2'h0, cs = 2'h1, pre = 2'h0;
  logic [7:0] wdata = 8'h00, lo, hi, pn = 8'h00;
  logic flag, wake, pin, go = 1'b0, busy;
  int err_total = 0, checks = 0, wakes = 0;
  gst_row_t rows [14] = '{'{1,0,0,0,0,1,0,20,20,0}, '{1,0,0,0,0,1,1,20,10,0}, '{1,0,0,0,0,1,2,20,5,0},
    '{1,0,0,0,0,1,3,24,3,0}, '{1,0,0,0,0,0,0,40,10,0}, '{1,0,0,0,0,0,1,40,5,0}, '{1,0,0,0,0,3,0,100,10,1},
    '{0,0,0,0,0,1,0,16,0,0}, '{1,1,1,1,0,1,0,16,16,0}, '{1,1,1,0,0,1,0,16,0,0}, '{1,1,0,0,0,1,0,16,16,0},
    '{1,1,1,1,1,1,0,16,16,0}, '{1,1,0,1,2,1,0,16,0,0}, '{1,1,1,1,3,1,0,16,16,0}};

  gst_timer_core gst_timer_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .counter_on_bit_i(on),
    .gate_enable_bit_i(ge), .gate_polarity_bit_i(pol), .gate_source_field_i(gs), .clock_select_field_i(cs),
    .prescale_field_i(pre), .sync_disable_bit_i(sdis), .sleep_i(sleep), .external_count_input_i(pin),
    .low_freq_internal_osc_i(lfo), .gate_input_pin_i(gpin), .companion_timer_wrap_pulse_i(wrap),
    .comparator_one_output_i(c1), .comparator_two_output_i(c2), .wr_low_i(wr_lo), .wr_high_i(wr_hi),
    .wr_data_i(wdata), .flag_clr_i(fclr), .count_low_byte_o(lo), .count_high_byte_o(hi),
    .overflow_flag_o(flag), .wake_o(wake));
  gst_ext_src gst_ext_src_i (.clk_i(clk_i), .go_i(go), .n_i(pn), .half_i(8'h04), .pin_o(pin), .busy_o(busy));

  // ****************************************************************
  // Clock, slow oscillator, wake counter, watchdog
  // ****************************************************************
  // 125 MHz clock; slow oscillator has a ten-cycle period
  always #4 clk_i = ~clk_i;
  always begin
    repeat (5) @(posedge clk_i);
    #1 lfo = ~lfo;
  end
  // Wake pulse is counted mid-cycle, where it is settled
  always @(negedge clk_i) if (wake === 1'b1) wakes++;
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task step();
    @(posedge clk_i);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
    checks++;
    if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp)) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write the same byte to both halves
  task put(input logic [7:0] v);
    wdata = v;
    wr_lo = 1'b1;
    wr_hi = 1'b1;
    step();
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    step();
  endtask
  task run_row(input gst_row_t r);
    cs = r.cs[1:0];
    pre = r.pre[1:0];
    ge = r.ge[0];
    pol = r.pol[0];
    gs = r.gs[1:0];
    // Only the selected source carries the level; the others carry its inverse
    gpin = (r.gs == 0) ? r.gl[0] : !r.gl[0];
    wrap = (r.gs == 1) ? r.gl[0] : !r.gl[0];
    c1 = (r.gs == 2) ? r.gl[0] : !r.gl[0];
    c2 = (r.gs == 3) ? r.gl[0] : !r.gl[0];
    put(8'h00);
    repeat (4) step();
    on = r.on[0];
    repeat (r.n) step();
    on = 1'b0;
    repeat (6) step();
    chk({hi, lo}, r.exp[15:0], r.tol);
  endtask
  task ext(input logic sd, input logic sl, input logic [1:0] p, input int n, input int e, input logic [7:0] w);
    int k;
    cs = 2'h2;
    sdis = sd;
    pre = p;
    ge = 1'b0;
    put(w);
    on = 1'b1;
    sleep = sl;
    pn = n[7:0];
    go = 1'b1;
    step();
    go = 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 2000) begin
      step();
      k++;
    end
    chk({15'h0000, (k >= 2000)}, 16'h0000, 0);
    repeat (6) step();
    on = 1'b0;
    sleep = 1'b0;
    chk({hi, lo}, e[15:0], 0);
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int k;
    repeat (4) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk({hi, lo}, 16'h0000, 0);
    chk({15'h0000, flag}, 16'h0000, 0);
    foreach (rows[i]) run_row(rows[i]);
    // Write while counting every cycle: written byte wins
    cs = 2'h1;
    pre = 2'h0;
    ge = 1'b0;
    on = 1'b1;
    repeat (3) step();
    wdata = 8'h34;
    wr_lo = 1'b1;
    step();
    wr_lo = 1'b0;
    chk({8'h00, lo}, 16'h0034, 0);
    wdata = 8'h12;
    wr_hi = 1'b1;
    step();
    wr_hi = 1'b0;
    chk({8'h00, hi}, 16'h0012, 0);
    chk({8'h00, lo}, 16'h0034, 0);
    on = 1'b0;
    // Partial prescale count must be dropped by a write
    pre = 2'h3;
    put(8'h00);
    on = 1'b1;
    repeat (5) step();
    on = 1'b0;
    put(8'h00);
    on = 1'b1;
    repeat (7) step();
    on = 1'b0;
    repeat (6) step();
    chk({hi, lo}, 16'h0000, 0);
    // Wrap from all ones, sticky flag, then clear
    pre = 2'h0;
    put(8'hFF);
    on = 1'b1;
    k = 0;
    while (flag !== 1'b1 && k < 20) begin
      step();
      k++;
    end
    chk({15'h0000, (k >= 20)}, 16'h0000, 0);
    on = 1'b0;
    repeat (5) step();
    chk({15'h0000, flag}, 16'h0001, 0);
    chk({hi, lo}, 16'h0000, 0);
    fclr = 1'b1;
    step();
    fclr = 1'b0;
    step();
    chk({15'h0000, flag}, 16'h0000, 0);
    // External pin: synchronous, asynchronous, prescaled, asleep
    ext(1'b0, 1'b0, 2'h0, 5, 5, 8'h00);
    ext(1'b1, 1'b0, 2'h0, 5, 5, 8'h00);
    ext(1'b1, 1'b0, 2'h2, 8, 2, 8'h00);
    ext(1'b0, 1'b1, 2'h0, 3, 0, 8'h00);
    ext(1'b1, 1'b1, 2'h0, 2, 1, 8'hFF);
    chk({15'h0000, flag}, 16'h0001, 0);
    chk(wakes[15:0], 16'h0001, 0);
    // System clock source stops while asleep
    cs = 2'h1;
    pre = 2'h0;
    put(8'h00);
    sleep = 1'b1;
    on = 1'b1;
    repeat (10) step();
    on = 1'b0;
    sleep = 1'b0;
    step();
    chk({hi, lo}, 16'h0000, 0);
    // Reset while stopped with the flag still set clears count and flag
    rst_n_i = 1'b0;
    step();
    chk({hi, lo}, 16'h0000, 0);
    chk({15'h0000, flag}, 16'h0000, 0);
    rst_n_i = 1'b1;
    step();
    tally_and_finish();
  end
endmodule
